/* File: bench/ext_mem_model.sv */
// External program memory model answering cache fills
`timescale 1ns/100ps
module ext_mem_model
(
	input wire logic sys_clk_i,
	input wire logic ext_rd_i,
	input wire logic [instruction_cache_pkg::ADDR_W-1:0] ext_addr_i,
	output logic [instruction_cache_pkg::DATA_W-1:0] ext_data_o
);
	logic [instruction_cache_pkg::DATA_W-1:0] last_q;
	// Word is a fixed scramble of its address; idle bus shows inverse of the previous cycle's value
	assign ext_data_o = ext_rd_i ? ext_addr_i ^ 24'h3c5a96 : ~last_q;
	always_ff @(posedge sys_clk_i)
	begin
		last_q <= ext_data_o;
	end
endmodule

/* File: bench/testbench.sv */
// Self-checking testbench of the sectored instruction cache
`timescale 1ns/100ps
module testbench;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, fetch_req = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rd_q;
	logic [1:0] bresp, rresp, resp_q;
	logic awready, wready, bvalid, arready, rvalid;
	logic [23:0] fetch_addr = 24'h0, fetch_data, ext_addr, ext_data;
	logic fetch_valid, ext_rd, illegal_op, cache_active;
	int miscompares = 0, comparisons = 0, ext_cyc = 0, ill_cnt = 0;

	sectored_instruction_cache DUT
	(
		.sys_clk_i(sys_clk), .rst_i(rst),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .fetch_req_i(fetch_req),
		.fetch_addr_i(fetch_addr), .fetch_valid_o(fetch_valid),
		.fetch_data_o(fetch_data), .ext_rd_o(ext_rd),
		.ext_addr_o(ext_addr), .ext_data_i(ext_data),
		.illegal_op_o(illegal_op), .cache_active_o(cache_active)
	);

	ext_mem_model mem
	(
		.sys_clk_i(sys_clk), .ext_rd_i(ext_rd),
		.ext_addr_i(ext_addr), .ext_data_o(ext_data)
	);

	initial
	begin
		forever #5 sys_clk = ~sys_clk;
	end

	// Counts external read cycles and illegal-op pulses
	always @(negedge sys_clk)
	begin
		if (ext_rd === 1'b1) ext_cyc++;
		if (illegal_op === 1'b1) ill_cnt++;
	end

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic axi_wr(logic [7:0] a, logic [31:0] d);
		bit aw_hs, w_hs, b_hs;
		b_hs = 1'b0;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_hs)
		begin
			@(negedge sys_clk);
			aw_hs = awvalid && awready;
			w_hs = wvalid && wready;
			b_hs = bvalid === 1'b1;
			resp_q = bresp;
			@(posedge sys_clk);
			if (aw_hs) awvalid <= 1'b0;
			if (w_hs) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask

	task automatic axi_rd(logic [7:0] a);
		bit ar_hs, r_hs;
		r_hs = 1'b0;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_hs)
		begin
			@(negedge sys_clk);
			ar_hs = arvalid && arready;
			r_hs = rvalid === 1'b1;
			rd_q = rdata;
			resp_q = rresp;
			@(posedge sys_clk);
			if (ar_hs) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask

	// One fetch; expects the given count of external read cycles
	task automatic fetch(logic [23:0] a, int exp_cyc);
		int c0;
		bit done;
		done = 1'b0;
		@(posedge sys_clk);
		fetch_addr <= a;
		fetch_req <= 1'b1;
		c0 = ext_cyc;
		while (!done)
		begin
			@(negedge sys_clk);
			done = fetch_valid === 1'b1;
		end
		check("fetch data", {8'h00, fetch_data}, {8'h00, a ^ 24'h3c5a96});
		check("ext cycles", ext_cyc - c0, exp_cyc);
		@(posedge sys_clk);
		fetch_req <= 1'b0;
	endtask

	task automatic t_reset();
		axi_rd(instruction_cache_pkg::REG_STATUS);
		check("status", rd_q, 32'h0);
		check("status resp", resp_q, instruction_cache_pkg::RESP_OKAY);
		axi_rd(instruction_cache_pkg::REG_STATE);
		check("state", rd_q, 32'h0);
		@(negedge sys_clk);
		check("active", cache_active, 1'b0);
		$display("test reset done");
	endtask

	task automatic t_disabled();
		int i0;
		i0 = ill_cnt;
		fetch(24'h000123, 1);
		axi_wr(instruction_cache_pkg::REG_OP, 32'h3);
		check("illegal pulse", ill_cnt - i0, 1);
		axi_rd(instruction_cache_pkg::REG_STATE);
		check("illegal flag", rd_q[9], 1'b1);
		axi_wr(instruction_cache_pkg::REG_STATE, 32'h0000_0200);
		axi_rd(instruction_cache_pkg::REG_STATE);
		check("illegal clear", rd_q[9], 1'b0);
		axi_rd(8'h18);
		check("unmapped rd", resp_q, instruction_cache_pkg::RESP_SLVERR);
		axi_wr(8'h1c, 32'h1);
		check("unmapped wr", resp_q, instruction_cache_pkg::RESP_SLVERR);
		$display("test disabled done");
	endtask

	task automatic t_single();
		axi_wr(instruction_cache_pkg::REG_WAIT, 32'h2);
		axi_wr(instruction_cache_pkg::REG_STATUS, 32'h0008_0000);
		@(negedge sys_clk);
		check("active", cache_active, 1'b1);
		fetch(24'h012345, 3);
		fetch(24'h012345, 0);
		fetch(24'h012346, 3);
		$display("test single done");
	endtask

	task automatic t_burst();
		axi_wr(instruction_cache_pkg::REG_WAIT, 32'h0);
		axi_wr(instruction_cache_pkg::REG_OPMODE, 32'h0000_0400);
		for (int k = 0; k < 4; k++)
		begin
			fetch({17'h00100 + 17'(k), 7'(16 + k)}, 4 - k);
		end
		fetch({17'h00100, 7'h13}, 0);
		axi_wr(instruction_cache_pkg::REG_OPMODE, 32'h0);
		$display("test burst done");
	endtask

	task automatic t_lru();
		axi_wr(instruction_cache_pkg::REG_OP, 32'h3);
		fetch(24'h012345, 1);
		axi_wr(instruction_cache_pkg::REG_OPADDR, 32'h012345);
		axi_wr(instruction_cache_pkg::REG_OP, 32'h1);
		axi_rd(instruction_cache_pkg::REG_STATE);
		check("lock mask", rd_q[7:0], 8'h80);
		for (int k = 1; k < 9; k++)
		begin
			fetch({17'h00200 + 17'(k), 7'h05}, 1);
		end
		fetch(24'h012345, 0);
		fetch({17'h00201, 7'h05}, 1);
		axi_wr(instruction_cache_pkg::REG_OP, 32'h2);
		check("op resp", resp_q, instruction_cache_pkg::RESP_OKAY);
		axi_rd(instruction_cache_pkg::REG_STATE);
		check("unlock mask", rd_q[7:0], 8'h00);
		$display("test lru done");
	endtask

	task automatic complete_run();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		#300000;
		miscompares++;
		complete_run();
	end

	initial
	begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_disabled();
		t_single();
		t_burst();
		t_lru();
		complete_run();
	end
endmodule

/* File: rtl/fill_reader.sv */
// External program memory reader for single and burst fills
`timescale 1ns/100ps
module fill_reader
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [instruction_cache_pkg::ADDR_W-1:0] addr_i,
	input wire logic [instruction_cache_pkg::CNT_W-1:0] count_i,
	input wire logic [instruction_cache_pkg::WAIT_W-1:0] wait_i,
	input wire logic [instruction_cache_pkg::DATA_W-1:0] ext_data_i,
	output instruction_cache_pkg::ext_req_s ext_req_o,
	output logic word_o,
	output logic [instruction_cache_pkg::ADDR_W-1:0] word_addr_o,
	output logic [instruction_cache_pkg::DATA_W-1:0] word_data_o,
	output logic done_o
);
	logic act_q;
	logic [instruction_cache_pkg::ADDR_W-1:0] addr_q;
	logic [instruction_cache_pkg::CNT_W-1:0] left_q;
	logic [instruction_cache_pkg::WAIT_W-1:0] cnt_q;
	logic [instruction_cache_pkg::WAIT_W-1:0] wait_q;
	logic last_beat;

	assign last_beat = act_q && (cnt_q == wait_q);
	assign ext_req_o = '{rd: act_q, addr: addr_q};

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			act_q <= 1'b0;
			addr_q <= '0;
			left_q <= '0;
			cnt_q <= '0;
			wait_q <= '0;
			word_o <= 1'b0;
			done_o <= 1'b0;
			word_addr_o <= '0;
			word_data_o <= '0;
		end
		else
		begin
			word_o <= last_beat;
			done_o <= last_beat && (left_q == 3'h1);
			if (last_beat)
			begin
				word_addr_o <= addr_q;
				word_data_o <= ext_data_i;
			end
			if (start_i && !act_q)
			begin
				act_q <= 1'b1;
				addr_q <= addr_i;
				left_q <= count_i;
				wait_q <= wait_i;
				cnt_q <= '0;
			end
			else if (last_beat)
			begin
				cnt_q <= '0;
				addr_q <= addr_q + 24'h1;
				left_q <= left_q - 3'h1;
				act_q <= (left_q != 3'h1);
			end
			else if (act_q)
				cnt_q <= cnt_q + 4'h1;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	beat_short_a: assert property (act_q && cnt_q != wait_q |=> !word_o)
		else $error("word delivered before wait states elapsed");
	beat_end_a: assert property (last_beat |=> word_o && word_data_o == $past(ext_data_i))
		else $error("word not captured at end of access");
endmodule

/* File: rtl/instruction_cache_pkg.sv */
// Shared constants, types and register map of the sectored instruction cache
package instruction_cache_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 24;
	localparam int OFF_W = 7;
	localparam int TAG_W = 17;
	localparam int SEC_N = 8;
	localparam int SEC_W = 3;
	localparam int WORDS = 128;
	localparam int ARRAY_W = 10;
	localparam int WAIT_W = 4;
	localparam int CNT_W = 3;
	localparam int AXI_AW = 8;
	localparam logic [TAG_W-1:0] TAG_RST = 17'h1ffff;
	localparam logic [WAIT_W-1:0] WAIT_RST = 4'h0;
	localparam logic [CNT_W-1:0] BURST_MAX = 3'h4;
	localparam int CE_BIT = 19;
	localparam int BURST_BIT = 10;
	localparam int BUSY_BIT = 8;
	localparam int ILL_BIT = 9;
	localparam int PEND_BIT = 2;
	localparam logic [AXI_AW-1:0] REG_STATUS = 8'h00;
	localparam logic [AXI_AW-1:0] REG_OPMODE = 8'h04;
	localparam logic [AXI_AW-1:0] REG_WAIT = 8'h08;
	localparam logic [AXI_AW-1:0] REG_OP = 8'h0c;
	localparam logic [AXI_AW-1:0] REG_OPADDR = 8'h10;
	localparam logic [AXI_AW-1:0] REG_STATE = 8'h14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0]
	{
		OP_NONE = 2'b00,
		OP_LOCK = 2'b01,
		OP_UNLOCK = 2'b10,
		OP_FLUSH = 2'b11
	} cache_op_e;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_FILL = 2'b01,
		ST_RESP = 2'b10
	} ctl_state_e;

	typedef struct packed
	{
		logic rd;
		logic [ADDR_W-1:0] addr;
	} ext_req_s;

	typedef struct packed
	{
		logic en;
		logic burst;
		logic [WAIT_W-1:0] wait_n;
		logic pend;
		logic [1:0] op;
		logic [ADDR_W-1:0] op_addr;
		logic ill;
		logic busy;
		logic [SEC_N-1:0] lock;
	} regs_s;
endpackage

/* File: rtl/lru_stack.sv */
// Recency stack of the eight sectors with locked-sector skipping
`timescale 1ns/100ps
module lru_stack
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic flush_i,
	input wire logic touch_i,
	input wire logic [instruction_cache_pkg::SEC_W-1:0] touch_sec_i,
	input wire logic [instruction_cache_pkg::SEC_N-1:0] lock_i,
	output logic [instruction_cache_pkg::SEC_W-1:0] victim_o,
	output logic victim_ok_o
);
	logic [instruction_cache_pkg::SEC_W-1:0] order_q [instruction_cache_pkg::SEC_N];
	logic [instruction_cache_pkg::SEC_W-1:0] order_d [instruction_cache_pkg::SEC_N];
	logic [instruction_cache_pkg::SEC_W-1:0] pos;

	// Position of the touched sector, then move it to the top
	always_comb
	begin
		pos = '0;
		for (int i = 0; i < instruction_cache_pkg::SEC_N; i++)
			if (order_q[i] == touch_sec_i)
				pos = instruction_cache_pkg::SEC_W'(i);
		order_d[0] = touch_sec_i;
		for (int i = 1; i < instruction_cache_pkg::SEC_N; i++)
			order_d[i] = (i <= int'(pos)) ? order_q[i-1] : order_q[i];
	end

	// Deepest unlocked entry wins; locked ones are skipped
	always_comb
	begin
		victim_o = '0;
		victim_ok_o = 1'b0;
		for (int i = 0; i < instruction_cache_pkg::SEC_N; i++)
			if (!lock_i[order_q[i]])
			begin
				victim_o = order_q[i];
				victim_ok_o = 1'b1;
			end
	end

	always_ff @(posedge sys_clk_i)
	begin
		for (int i = 0; i < instruction_cache_pkg::SEC_N; i++)
			if (rst_i || flush_i)
				order_q[i] <= instruction_cache_pkg::SEC_W'(i);
			else if (touch_i)
				order_q[i] <= order_d[i];
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	mru_top_a: assert property (touch_i && !flush_i |=> order_q[0] == $past(touch_sec_i))
		else $error("touched sector not most recent");
	victim_free_a: assert property (victim_ok_o |-> !lock_i[victim_o])
		else $error("locked sector picked as victim");
	stack_hold_a: assert property (!touch_i && !flush_i |=> $stable(order_q[7]))
		else $error("recency stack moved without cause");
endmodule

/* File: rtl/sectored_instruction_cache.sv */
// Eight-sector fully associative instruction cache with AXI4-Lite control
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module sectored_instruction_cache
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [instruction_cache_pkg::AXI_AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [instruction_cache_pkg::AXI_AW-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic fetch_req_i,
	input wire logic [instruction_cache_pkg::ADDR_W-1:0] fetch_addr_i,
	output logic fetch_valid_o,
	output logic [instruction_cache_pkg::DATA_W-1:0] fetch_data_o,
	output logic ext_rd_o,
	output logic [instruction_cache_pkg::ADDR_W-1:0] ext_addr_o,
	input wire logic [instruction_cache_pkg::DATA_W-1:0] ext_data_i,
	output logic illegal_op_o,
	output logic cache_active_o
);
	function automatic logic [31:0] reg_read(
		input logic [instruction_cache_pkg::AXI_AW-1:0] a,
		input instruction_cache_pkg::regs_s r);
		logic [31:0] v;
		v = 32'h0;
		case (a)
			instruction_cache_pkg::REG_STATUS: v[instruction_cache_pkg::CE_BIT] = r.en;
			instruction_cache_pkg::REG_OPMODE: v[instruction_cache_pkg::BURST_BIT] = r.burst;
			instruction_cache_pkg::REG_WAIT: v = {28'h0, r.wait_n};
			instruction_cache_pkg::REG_OP: v = {29'h0, r.pend, r.op};
			instruction_cache_pkg::REG_OPADDR: v = {8'h0, r.op_addr};
			instruction_cache_pkg::REG_STATE: v = {22'h0, r.ill, r.busy, r.lock};
			default: v = 32'h0;
		endcase
		return v;
	endfunction

	function automatic logic mapped(input logic [instruction_cache_pkg::AXI_AW-1:0] a);
		return a inside {instruction_cache_pkg::REG_STATUS, instruction_cache_pkg::REG_OPMODE,
			instruction_cache_pkg::REG_WAIT, instruction_cache_pkg::REG_OP,
			instruction_cache_pkg::REG_OPADDR, instruction_cache_pkg::REG_STATE};
	endfunction

	function automatic logic [instruction_cache_pkg::SEC_W-1:0] enc(
		input logic [instruction_cache_pkg::SEC_N-1:0] v);
		logic [instruction_cache_pkg::SEC_W-1:0] s;
		s = '0;
		for (int i = 0; i < instruction_cache_pkg::SEC_N; i++)
			if (v[i])
				s = instruction_cache_pkg::SEC_W'(i);
		return s;
	endfunction

	// Cache storage
	logic [instruction_cache_pkg::DATA_W-1:0] mem_q [2**instruction_cache_pkg::ARRAY_W];
	logic [instruction_cache_pkg::WORDS-1:0] valid_q [instruction_cache_pkg::SEC_N];
	logic [instruction_cache_pkg::TAG_W-1:0] tag_q [instruction_cache_pkg::SEC_N];
	logic [instruction_cache_pkg::SEC_N-1:0] lock_q;

	// Control registers
	logic en_q;
	logic burst_q;
	logic [instruction_cache_pkg::WAIT_W-1:0] wait_q;
	logic op_pend_q;
	instruction_cache_pkg::cache_op_e op_q;
	logic [instruction_cache_pkg::ADDR_W-1:0] op_addr_q;
	logic ill_q;
	logic ill_pulse_q;
	instruction_cache_pkg::regs_s regs;

	// Bus slave state
	logic aw_full_q;
	logic w_full_q;
	logic [instruction_cache_pkg::AXI_AW-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_fire;
	logic [31:0] wr_old;
	logic [31:0] wr_val;
	logic wr_st, wr_om, wr_wt, wr_op, wr_oa, wr_sa;
	logic op_req;

	// Fetch control
	instruction_cache_pkg::ctl_state_e st_q;
	logic [instruction_cache_pkg::ADDR_W-1:0] req_addr_q;
	logic fill_store_q;
	logic fill_burst_q;
	logic [instruction_cache_pkg::SEC_W-1:0] fill_sec_q;
	logic [instruction_cache_pkg::DATA_W-1:0] rsp_q;
	logic [instruction_cache_pkg::TAG_W-1:0] ftag, otag;
	logic [instruction_cache_pkg::OFF_W-1:0] foff;
	logic [instruction_cache_pkg::SEC_N-1:0] hit_vec, op_vec;
	logic sec_hit, op_hit, word_ok;
	logic [instruction_cache_pkg::SEC_W-1:0] hit_sec, op_sec;
	logic [instruction_cache_pkg::DATA_W-1:0] hit_word;
	logic go_op, go_fetch, do_hit, f_miss, f_store, f_alloc, f_burst;
	logic lock_op, op_ok, op_alloc, flush_en, alloc_en, touch_en;
	logic [instruction_cache_pkg::TAG_W-1:0] alloc_tag;
	logic [instruction_cache_pkg::SEC_W-1:0] victim, touch_sec, lock_sec;
	logic victim_ok;
	logic [instruction_cache_pkg::CNT_W-1:0] rd_cnt;
	instruction_cache_pkg::ext_req_s ext_req;
	logic rd_word, rd_done;
	logic [instruction_cache_pkg::ADDR_W-1:0] rd_waddr;
	logic [instruction_cache_pkg::DATA_W-1:0] rd_wdata;
	logic word_store;

	assign regs = '{en: en_q, burst: burst_q, wait_n: wait_q, pend: op_pend_q,
		op: op_q, op_addr: op_addr_q, ill: ill_q,
		busy: st_q != instruction_cache_pkg::ST_IDLE, lock: lock_q};

	// AXI4-Lite slave
	assign s_axi_awready_o = !aw_full_q && !s_axi_bvalid_o;
	assign s_axi_wready_o = !w_full_q && !s_axi_bvalid_o;
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid_o;
	assign wr_old = reg_read(aw_addr_q, regs);
	for (genvar b = 0; b < 4; b++)
	begin : g_strb
		assign wr_val[b*8 +: 8] = w_strb_q[b] ? w_data_q[b*8 +: 8]
			: wr_old[b*8 +: 8];
	end
	assign wr_st = wr_fire && aw_addr_q == instruction_cache_pkg::REG_STATUS;
	assign wr_om = wr_fire && aw_addr_q == instruction_cache_pkg::REG_OPMODE;
	assign wr_wt = wr_fire && aw_addr_q == instruction_cache_pkg::REG_WAIT;
	assign wr_op = wr_fire && aw_addr_q == instruction_cache_pkg::REG_OP && w_strb_q[0];
	assign wr_oa = wr_fire && aw_addr_q == instruction_cache_pkg::REG_OPADDR;
	assign wr_sa = wr_fire && aw_addr_q == instruction_cache_pkg::REG_STATE;
	assign op_req = wr_op && wr_val[1:0] != instruction_cache_pkg::OP_NONE;

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= instruction_cache_pkg::RESP_OKAY;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rresp_o <= instruction_cache_pkg::RESP_OKAY;
			s_axi_rdata_o <= '0;
		end
		else
		begin
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr_i;
			end
			else if (wr_fire)
				aw_full_q <= 1'b0;
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata_i;
				w_strb_q <= s_axi_wstrb_i;
			end
			else if (wr_fire)
				w_full_q <= 1'b0;
			if (wr_fire)
			begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= mapped(aw_addr_q) ? instruction_cache_pkg::RESP_OKAY
					: instruction_cache_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
			if (s_axi_arvalid_i && s_axi_arready_o)
			begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= reg_read(s_axi_araddr_i, regs);
				s_axi_rresp_o <= mapped(s_axi_araddr_i) ? instruction_cache_pkg::RESP_OKAY
					: instruction_cache_pkg::RESP_SLVERR;
			end
			else if (s_axi_rready_i)
				s_axi_rvalid_o <= 1'b0;
		end
	end

	// Control register file
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			en_q <= 1'b0;
			burst_q <= 1'b0;
			wait_q <= instruction_cache_pkg::WAIT_RST;
			op_pend_q <= 1'b0;
			op_q <= instruction_cache_pkg::OP_NONE;
			op_addr_q <= '0;
			ill_q <= 1'b0;
			ill_pulse_q <= 1'b0;
		end
		else
		begin
			if (wr_st)
				en_q <= wr_val[instruction_cache_pkg::CE_BIT];
			if (wr_om)
				burst_q <= wr_val[instruction_cache_pkg::BURST_BIT];
			if (wr_wt)
				wait_q <= wr_val[instruction_cache_pkg::WAIT_W-1:0];
			if (wr_oa)
				op_addr_q <= wr_val[instruction_cache_pkg::ADDR_W-1:0];
			if (op_req && en_q)
				op_q <= instruction_cache_pkg::cache_op_e'(wr_val[1:0]);
			op_pend_q <= (op_req && en_q) || (op_pend_q && !go_op);
			ill_pulse_q <= op_req && !en_q;
			ill_q <= (op_req && !en_q) || (ill_q && !(wr_sa
				&& wr_val[instruction_cache_pkg::ILL_BIT] && w_strb_q[1]));
		end
	end
	assign illegal_op_o = ill_pulse_q;
	assign cache_active_o = en_q;

	// Parallel tag compare for fetch and operation addresses
	assign ftag = fetch_addr_i[instruction_cache_pkg::ADDR_W-1:instruction_cache_pkg::OFF_W];
	assign foff = fetch_addr_i[instruction_cache_pkg::OFF_W-1:0];
	assign otag = op_addr_q[instruction_cache_pkg::ADDR_W-1:instruction_cache_pkg::OFF_W];
	for (genvar s = 0; s < instruction_cache_pkg::SEC_N; s++)
	begin : g_cmp
		assign hit_vec[s] = tag_q[s] == ftag;
		assign op_vec[s] = tag_q[s] == otag;
	end
	assign sec_hit = |hit_vec;
	assign op_hit = |op_vec;
	assign hit_sec = enc(hit_vec);
	assign op_sec = enc(op_vec);
	assign word_ok = valid_q[hit_sec][foff];
	assign hit_word = mem_q[{hit_sec, foff}];

	// Dispatch from idle; pending cache ops go first
	assign go_op = st_q == instruction_cache_pkg::ST_IDLE && op_pend_q;
	assign go_fetch = st_q == instruction_cache_pkg::ST_IDLE && !op_pend_q && fetch_req_i;
	assign do_hit = go_fetch && en_q && sec_hit && word_ok;
	assign f_miss = go_fetch && !(en_q && sec_hit && word_ok);
	assign f_store = en_q && (sec_hit || victim_ok);
	assign f_alloc = go_fetch && en_q && !sec_hit && victim_ok;
	assign f_burst = burst_q && f_store;
	assign rd_cnt = f_burst ? instruction_cache_pkg::BURST_MAX - {1'b0, fetch_addr_i[1:0]}
		: 3'h1;
	assign lock_op = op_q == instruction_cache_pkg::OP_LOCK || op_q == instruction_cache_pkg::OP_UNLOCK;
	assign op_ok = op_hit || victim_ok;
	assign op_alloc = go_op && lock_op && !op_hit && victim_ok;
	assign flush_en = go_op && op_q == instruction_cache_pkg::OP_FLUSH;
	assign alloc_en = f_alloc || op_alloc;
	assign alloc_tag = f_alloc ? ftag : otag;
	assign lock_sec = op_hit ? op_sec : victim;
	assign touch_en = do_hit || (f_miss && f_store) || (go_op && lock_op && op_ok);
	assign touch_sec = go_op ? lock_sec : (sec_hit ? hit_sec : victim);
	assign word_store = st_q == instruction_cache_pkg::ST_FILL && rd_word && fill_store_q;

	lru_stack u_lru
	(
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.flush_i(flush_en),
		.touch_i(touch_en),
		.touch_sec_i(touch_sec),
		.lock_i(lock_q),
		.victim_o(victim),
		.victim_ok_o(victim_ok)
	);

	fill_reader u_reader
	(
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.start_i(f_miss),
		.addr_i(fetch_addr_i),
		.count_i(rd_cnt),
		.wait_i(wait_q),
		.ext_data_i(ext_data_i),
		.ext_req_o(ext_req),
		.word_o(rd_word),
		.word_addr_o(rd_waddr),
		.word_data_o(rd_wdata),
		.done_o(rd_done)
	);
	assign ext_rd_o = ext_req.rd;
	assign ext_addr_o = ext_req.addr;

	// Tags, valid bits and locks
	always_ff @(posedge sys_clk_i)
	begin
		for (int s = 0; s < instruction_cache_pkg::SEC_N; s++)
		begin
			if (rst_i || flush_en)
			begin
				tag_q[s] <= instruction_cache_pkg::TAG_RST;
				valid_q[s] <= '0;
			end
			else if (alloc_en && victim == instruction_cache_pkg::SEC_W'(s))
			begin
				tag_q[s] <= alloc_tag;
				valid_q[s] <= '0;
			end
			else if (word_store && fill_sec_q == instruction_cache_pkg::SEC_W'(s))
				valid_q[s][rd_waddr[instruction_cache_pkg::OFF_W-1:0]] <= 1'b1;
		end
		if (rst_i || flush_en)
			lock_q <= '0;
		else if (go_op && lock_op && op_ok)
			lock_q[lock_sec] <= op_q == instruction_cache_pkg::OP_LOCK;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (word_store)
			mem_q[{fill_sec_q, rd_waddr[instruction_cache_pkg::OFF_W-1:0]}] <= rd_wdata;
	end

	// Fetch sequencer
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			st_q <= instruction_cache_pkg::ST_IDLE;
			req_addr_q <= '0;
			fill_store_q <= 1'b0;
			fill_burst_q <= 1'b0;
			fill_sec_q <= '0;
			rsp_q <= '0;
		end
		else
		begin
			unique case (st_q)
				instruction_cache_pkg::ST_IDLE:
					if (do_hit)
					begin
						rsp_q <= hit_word;
						st_q <= instruction_cache_pkg::ST_RESP;
					end
					else if (f_miss)
					begin
						req_addr_q <= fetch_addr_i;
						fill_store_q <= f_store;
						fill_burst_q <= f_burst;
						fill_sec_q <= sec_hit ? hit_sec : victim;
						st_q <= instruction_cache_pkg::ST_FILL;
					end
				instruction_cache_pkg::ST_FILL:
				begin
					if (rd_word && rd_waddr == req_addr_q)
						rsp_q <= rd_wdata;
					if (rd_done)
						st_q <= instruction_cache_pkg::ST_RESP;
				end
				instruction_cache_pkg::ST_RESP:
					st_q <= instruction_cache_pkg::ST_IDLE;
			endcase
		end
	end
	assign fetch_valid_o = st_q == instruction_cache_pkg::ST_RESP;
	assign fetch_data_o = rsp_q;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	hit_word_a: assert property (do_hit |=> fetch_valid_o && fetch_data_o == $past(hit_word))
		else $error("hit did not return the array word");
	hit_no_ext_a: assert property (do_hit |=> !ext_rd_o)
		else $error("hit started an external read");
	sector_flush_a: assert property (f_alloc |=> valid_q[$past(victim)] == '0
		&& tag_q[$past(victim)] == $past(ftag))
		else $error("victim not flushed and retagged");
	bypass_keep_a: assert property (go_fetch && !en_q |=> !fill_store_q && $stable(lock_q))
		else $error("disabled fetch altered cache state");
	burst_end_a: assert property (st_q == instruction_cache_pkg::ST_FILL && rd_done && fill_burst_q
		|-> rd_waddr[1:0] == 2'b11)
		else $error("burst did not end at block boundary");
	single_word_a: assert property (st_q == instruction_cache_pkg::ST_FILL && rd_word && !fill_burst_q
		|-> rd_done && rd_waddr == req_addr_q)
		else $error("single fill read more than one word");
	word_valid_a: assert property (word_store |=> valid_q[$past(fill_sec_q)]
		[$past(rd_waddr[instruction_cache_pkg::OFF_W-1:0])])
		else $error("filled word not marked valid");
	reset_state_a: assert property ($past(rst_i) || $past(flush_en) |-> lock_q == '0
		&& tag_q[0] == instruction_cache_pkg::TAG_RST && valid_q[7] == '0)
		else $error("reset or flush state wrong");
	illegal_op_a: assert property (op_req && !en_q |=> illegal_op_o
		&& op_q == $past(op_q))
		else $error("op while disabled not flagged illegal");
	en_bit_a: assert property (wr_st |=> en_q == $past(wr_val[instruction_cache_pkg::CE_BIT]))
		else $error("enable bit not taken from bit 19");

	hit_seen_c: cover property (do_hit);
	burst_four_c: cover property (f_miss && f_burst && fetch_addr_i[1:0] == 2'b00);
	lock_done_c: cover property (go_op && op_q == instruction_cache_pkg::OP_LOCK && op_alloc);
	flush_done_c: cover property (flush_en);
endmodule
